// ### bench/sesr_ctl_model.sv
// ==========================================
// bus controller: answers service requests
module sesr_ctl_model (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic srq_in,
  input wire logic srq_en_in,
  input wire logic poll_valid_in,
  input wire logic [7:0] poll_data_in,
  output logic poll_out,
  output logic [7:0] last_poll_out,
  output int poll_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wait_q;
  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      poll_out <= 1'b0;
      wait_q <= 1'b0;
      last_poll_out <= 8'h00;
      poll_cnt_out <= 0;
    end
    else
    begin
      // one poll per request, none while one is outstanding
      poll_out <= srq_in && srq_en_in && !poll_out && !wait_q;
      if (poll_out)
        wait_q <= 1'b1;
      if (poll_valid_in)
      begin
        wait_q <= 1'b0;
        last_poll_out <= poll_data_in;
        poll_cnt_out <= poll_cnt_out + 1;
      end
    end
  end
endmodule

// ### bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, reset_in = 1, en = 1, ques = 0, psc = 0, cmds = 1, store = 0, meas = 1, ctl_en = 0;
  logic [17:0] sv = '0;
  logic [7:0] wd = '0;
  logic srq, rv, pv, halt, elog, poll;
  logic [7:0] sb, rd, pd, lp;
  int pc, error_cnt = 0, cmp_count = 0;
  logic [7:0] wt [1:8] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h10, 8'h20};
  initial
  begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  sesr_top u_dut (.mclk_in, .reset_in, .clk_en_in(en), .opc_done_in(sv[0]), .empty_read_in(sv[1]),
    .query_interrupted_in(sv[2]), .buffers_full_in(sv[3]), .selftest_fail_in(sv[4]), .cal_fail_in(sv[5]),
    .overload_in(sv[6]), .exec_error_in(sv[7]), .command_error_in(sv[8]), .ques_summary_in(ques),
    .psc_setting_in(psc), .ese_saved_in(8'h01), .sre_saved_in(8'h60), .cls_in(sv[9]), .ese_write_in(sv[10]),
    .sre_write_in(sv[11]), .wdata_in(wd), .esr_query_in(sv[12]), .ese_query_in(sv[13]),
    .sre_query_in(sv[14]), .stb_query_in(sv[15]), .cmds_done_in(cmds), .serial_poll_in(poll),
    .msg_load_in(sv[16]), .msg_read_in(sv[17]), .store_mode_in(store), .meas_done_in(meas), .srq_out(srq),
    .status_byte_out(sb), .reply_data_out(rd), .reply_valid_out(rv), .poll_data_out(pd),
    .poll_valid_out(pv), .halt_readings_out(halt), .err_log_out(elog));
  sesr_ctl_model u_ctl (.mclk_in, .reset_in, .srq_in(srq), .srq_en_in(ctl_en), .poll_valid_in(pv), .poll_data_in(pd),
    .poll_out(poll), .last_poll_out(lp), .poll_cnt_out(pc));
  // ==========================================
  // helpers
  task chk8(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task chk1(string n, logic e, logic s);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, s);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task pulse(int i, logic [7:0] d = 8'h00);
    @(posedge mclk_in);
    sv <= 18'h00001 << i;
    wd <= d;
    @(posedge mclk_in);
    sv <= '0;
    #1;
  endtask
  task q(int i, logic [7:0] e);
    pulse(i);
    chk1("reply_valid", 1'b1, rv);
    chk8("reply", e, rd);
  endtask
  task rst(logic p);
    @(posedge mclk_in);
    reset_in <= 1'b1;
    psc <= p;
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b0;
    tick(2);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk_in);
    error_cnt++;
    print_verdict;
  end
  // ==========================================
  // tests
  initial
  begin
    rst(1'b0);
    q(13, 8'h01);
    q(14, 8'h20);
    q(12, 8'h80);
    q(12, 8'h00);
    $display("test power_on done");
    pulse(9);
    pulse(10, 8'h01);
    pulse(11, 8'h20);
    @(posedge mclk_in);
    ctl_en <= 1'b1;
    pulse(0);
    chk1("srq", 1'b1, srq);
    chk8("status", 8'h60, sb);
    tick(10);
    chk8("poll", 8'h60, lp);
    chk8("status", 8'h20, sb);
    @(posedge mclk_in);
    cmds <= 1'b0;
    pulse(15);
    tick(3);
    chk1("reply_valid", 1'b0, rv);
    @(posedge mclk_in);
    cmds <= 1'b1;
    tick(1);
    chk1("reply_valid", 1'b1, rv);
    chk8("stb", 8'h20, rd);
    chk8("status", 8'h20, sb);
    q(12, 8'h01);
    tick(1);
    chk8("status", 8'h00, sb);
    @(posedge mclk_in);
    ctl_en <= 1'b0;
    pulse(0);
    chk1("srq", 1'b1, srq);
    pulse(15);
    tick(1);
    chk1("reply_valid", 1'b1, rv);
    chk8("stb", 8'h60, rd);
    chk1("srq", 1'b1, srq);
    q(12, 8'h01);
    chk1("srq", 1'b0, srq);
    @(posedge mclk_in);
    ctl_en <= 1'b1;
    $display("test srq done");
    for (int i = 1; i <= 8; i++)
    begin
      pulse(i);
      chk1("err_log", i != 6, elog);
      q(12, wt[i]);
    end
    pulse(10, 8'h00);
    q(13, 8'h00);
    pulse(0);
    tick(1);
    chk1("srq", 1'b0, srq);
    q(12, 8'h01);
    @(posedge mclk_in);
    en <= 1'b0;
    pulse(0);
    @(posedge mclk_in);
    en <= 1'b1;
    q(12, 8'h00);
    $display("test events done");
    repeat (17) pulse(16);
    tick(1);
    chk1("halt", 1'b1, halt);
    chk1("mav", 1'b1, sb[4]);
    pulse(17);
    tick(1);
    chk1("halt", 1'b0, halt);
    repeat (14) pulse(17);
    tick(1);
    chk1("mav", 1'b1, sb[4]);
    pulse(17);
    tick(1);
    chk1("mav", 1'b0, sb[4]);
    @(posedge mclk_in);
    store <= 1'b1;
    meas <= 1'b0;
    pulse(16);
    tick(1);
    chk1("mav", 1'b0, sb[4]);
    @(posedge mclk_in);
    meas <= 1'b1;
    tick(1);
    chk1("mav", 1'b1, sb[4]);
    pulse(17);
    @(posedge mclk_in);
    store <= 1'b0;
    $display("test messages done");
    @(posedge mclk_in);
    ques <= 1'b1;
    tick(2);
    chk8("status", 8'h08, sb);
    pulse(11, 8'h48);
    tick(10);
    chk8("poll", 8'h48, lp);
    chk8("poll_count", 8'h02, pc[7:0]);
    q(14, 8'h08);
    @(posedge mclk_in);
    ques <= 1'b0;
    rst(1'b1);
    q(13, 8'h00);
    q(14, 8'h00);
    $display("test summary done");
    print_verdict;
  end
endmodule

// ### hdl/sesr_top.sv
// Contract
// - status byte bit 6 becoming set asserts the service request line
// - request enable mask selects which summary bits may raise a request
// - serial poll or reading the causing event register clears the request
// - serial poll returns status byte, clears only the request bit
// - status byte query returns same value but clears nothing
// - status byte query answers only after earlier commands complete
// - message available set on first queued reading, cleared when all read
// - with stored readings, message available waits for all measurements done
// - event bit 0 set when operation-complete command has executed
// - event bit 2 on empty read, interrupted query, or both buffers full
// - event bit 3 on self-test failure, calibration failure or overload
// - event bit 4 flags execution error, bit 5 command syntax error
// - event bit 7 set after power cycle until read or cleared
// - event summary is OR of event bits selected by enable mask
// - every error logged to the queue also sets an event bit 2 to 5
// - overload sets event bit 3 but logs no queue entry
// - event register cleared by clear-status and by event query
// - event enable cleared by writing zero, at power-on only if setting 1
// - full output buffer stops readings until one entry is read from it
// - status byte bits 3,4,5,6 defined; bits 0,1,2,7 read zero
// - event bits latch; further changes ignored while set
// - summary bits follow their sources and do not latch
`include "sesr_map.svh"

module sesr_top
  import sesr_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic opc_done_in,
  input wire logic empty_read_in,
  input wire logic query_interrupted_in,
  input wire logic buffers_full_in,
  input wire logic selftest_fail_in,
  input wire logic cal_fail_in,
  input wire logic overload_in,
  input wire logic exec_error_in,
  input wire logic command_error_in,
  input wire logic ques_summary_in,
  input wire logic psc_setting_in,
  input wire logic [7:0] ese_saved_in,
  input wire logic [7:0] sre_saved_in,
  input wire logic cls_in,
  input wire logic ese_write_in,
  input wire logic sre_write_in,
  input wire logic [7:0] wdata_in,
  input wire logic esr_query_in,
  input wire logic ese_query_in,
  input wire logic sre_query_in,
  input wire logic stb_query_in,
  input wire logic cmds_done_in,
  input wire logic serial_poll_in,
  input wire logic msg_load_in,
  input wire logic msg_read_in,
  input wire logic store_mode_in,
  input wire logic meas_done_in,
  output logic srq_out,
  output logic [7:0] status_byte_out,
  output logic [7:0] reply_data_out,
  output logic reply_valid_out,
  output logic [7:0] poll_data_out,
  output logic poll_valid_out,
  output logic halt_readings_out,
  output logic err_log_out
);

  // ==========================================================
  // state
  // ==========================================================
  sesr_state_t st_q, st_d;
  logic [7:0] ese_q, ese_d;
  logic [7:0] sre_q, sre_d;
  logic [7:0] standard_event_latch_q, standard_event_latch_d;
  logic [7:0] cnt_q, cnt_d;
  logic rqs_q, rqs_d;
  logic mss_q, mss_d;
  logic stb_pend_q, stb_pend_d;
  logic [7:0] stb_d, reply_data_d, poll_data_d, ev;
  logic reply_valid_d, poll_valid_d, halt_d, err_log_d, ess_d, mav_d;
  logic mss_rise, imm_rd, stb_ans, rqs_clr;

  // ==========================================================
  // event sources
  // ==========================================================
  always_comb
  begin
    ev = `SESR_ZERO8;
    ev[`SESR_B_OPC] = opc_done_in;
    ev[`SESR_B_QRY] = empty_read_in | query_interrupted_in | buffers_full_in;
    ev[`SESR_B_DEV] = selftest_fail_in | cal_fail_in | overload_in;
    ev[`SESR_B_EXE] = exec_error_in;
    ev[`SESR_B_CMD] = command_error_in;
    ev[`SESR_B_PON] = (st_q == sesr_st_init);
  end

  // ==========================================================
  // next-state logic
  // ==========================================================
  always_comb
  begin
    st_d = st_q;
    ese_d = ese_q;
    sre_d = sre_q;
    standard_event_latch_d = standard_event_latch_q;
    cnt_d = cnt_q;
    // power-on: masks stay cleared unless the stored setting keeps them
    unique case (st_q)
      sesr_st_init:
      begin
        st_d = sesr_st_run;
        if (!psc_setting_in)
        begin
          ese_d = ese_saved_in;
          sre_d = sre_saved_in & `SESR_SRE_MASK;
        end
      end
      sesr_st_run:
      begin
        st_d = sesr_st_run;
      end
    endcase
    if (ese_write_in)
    begin
      ese_d = wdata_in;
    end
    if (sre_write_in)
    begin
      sre_d = wdata_in & `SESR_SRE_MASK;
    end
    if (cls_in || esr_query_in)
    begin
      standard_event_latch_d = `SESR_ZERO8;
    end
    // new events win over a same-cycle clear
    standard_event_latch_d = (standard_event_latch_d | ev) & `SESR_USED_MASK;
    // output buffer occupancy
    if (msg_load_in && (cnt_q != `SESR_OBUF_DEPTH) && !(msg_read_in && (cnt_q != `SESR_ZERO8)))
    begin
      cnt_d = cnt_q + `SESR_ONE8;
    end
    else if (msg_read_in && (cnt_q != `SESR_ZERO8) && !(msg_load_in && (cnt_q != `SESR_OBUF_DEPTH)))
    begin
      cnt_d = cnt_q - `SESR_ONE8;
    end
    halt_d = (cnt_d == `SESR_OBUF_DEPTH);
    err_log_d = empty_read_in | query_interrupted_in | buffers_full_in | selftest_fail_in
              | cal_fail_in | exec_error_in | command_error_in;
  end

  // ==========================================================
  // status byte and service request
  // ==========================================================
  always_comb
  begin
    ess_d = |(standard_event_latch_d & ese_d);
    mav_d = (cnt_d != `SESR_ZERO8) && !(store_mode_in && !meas_done_in);
    stb_d = `SESR_ZERO8;
    stb_d[`SESR_STB_QUES] = ques_summary_in;
    stb_d[`SESR_STB_MAV] = mav_d;
    stb_d[`SESR_STB_ESS] = ess_d;
    mss_d = |(stb_d & sre_d & `SESR_SRE_MASK);
    mss_rise = mss_d && !mss_q;
    rqs_clr = serial_poll_in | cls_in;
    rqs_clr = rqs_clr | (esr_query_in & sre_q[`SESR_STB_ESS] & (|(standard_event_latch_q & ese_q)));
    // a new rising request wins over a same-cycle clear
    rqs_d = mss_rise | (rqs_q & ~rqs_clr);
    stb_d[`SESR_STB_RQS] = rqs_d;
  end

  // ==========================================================
  // replies
  // ==========================================================
  always_comb
  begin
    imm_rd = esr_query_in | ese_query_in | sre_query_in;
    stb_ans = stb_pend_q && cmds_done_in && !imm_rd;
    stb_pend_d = stb_query_in | (stb_pend_q & ~stb_ans);
    reply_valid_d = imm_rd | stb_ans;
    reply_data_d = `SESR_ZERO8;
    if (esr_query_in)
    begin
      reply_data_d = standard_event_latch_q;
    end
    else if (ese_query_in)
    begin
      reply_data_d = ese_q;
    end
    else if (sre_query_in)
    begin
      reply_data_d = sre_q;
    end
    else if (stb_ans)
    begin
      reply_data_d = status_byte_out;
    end
    poll_valid_d = serial_poll_in;
    poll_data_d = status_byte_out;
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      st_q <= sesr_st_init;
      ese_q <= `SESR_ZERO8;
      sre_q <= `SESR_ZERO8;
      standard_event_latch_q <= `SESR_ZERO8;
      cnt_q <= `SESR_ZERO8;
      rqs_q <= 1'b0;
      mss_q <= 1'b0;
      stb_pend_q <= 1'b0;
      srq_out <= 1'b0;
      status_byte_out <= `SESR_ZERO8;
      reply_data_out <= `SESR_ZERO8;
      reply_valid_out <= 1'b0;
      poll_data_out <= `SESR_ZERO8;
      poll_valid_out <= 1'b0;
      halt_readings_out <= 1'b0;
      err_log_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      st_q <= st_d;
      ese_q <= ese_d;
      sre_q <= sre_d;
      standard_event_latch_q <= standard_event_latch_d;
      cnt_q <= cnt_d;
      rqs_q <= rqs_d;
      mss_q <= mss_d;
      stb_pend_q <= stb_pend_d;
      srq_out <= rqs_d;
      status_byte_out <= stb_d;
      reply_data_out <= reply_data_d;
      reply_valid_out <= reply_valid_d;
      poll_data_out <= poll_data_d;
      poll_valid_out <= poll_valid_d;
      halt_readings_out <= halt_d;
      err_log_out <= err_log_d;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  property p_srq_rise;
    clk_en_in && mss_rise |=> srq_out && status_byte_out[`SESR_STB_RQS];
  endproperty
  a_srq_rise: assert property (p_srq_rise) else $error("request not raised");

  property p_mask_gate;
    clk_en_in && (sre_d == `SESR_ZERO8) && !rqs_q |=> !srq_out;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("request with empty mask");

  property p_poll_clear;
    clk_en_in && serial_poll_in && !mss_rise |=> !srq_out;
  endproperty
  a_poll_clear: assert property (p_poll_clear) else $error("poll left request set");

  property p_poll_data;
    clk_en_in && serial_poll_in |=> poll_valid_out && (poll_data_out == $past(status_byte_out));
  endproperty
  a_poll_data: assert property (p_poll_data) else $error("poll data wrong");

  property p_stb_keep;
    clk_en_in && stb_query_in && rqs_q && !serial_poll_in && !cls_in && !esr_query_in |=> srq_out;
  endproperty
  a_stb_keep: assert property (p_stb_keep) else $error("status query cleared request");

  sequence s_stb_ready;
    clk_en_in && stb_pend_q && cmds_done_in && !imm_rd && !stb_query_in;
  endsequence
  sequence s_stb_answer;
    reply_valid_out && !stb_pend_q && (reply_data_out == $past(status_byte_out));
  endsequence
  property p_stb_order;
    s_stb_ready |=> s_stb_answer;
  endproperty
  a_stb_order: assert property (p_stb_order) else $error("status query answer wrong");

  property p_stb_wait;
    clk_en_in && stb_pend_q && !cmds_done_in && !imm_rd |=> !reply_valid_out && stb_pend_q;
  endproperty
  a_stb_wait: assert property (p_stb_wait) else $error("status query answered early");

  property p_mav_set;
    clk_en_in && (cnt_d != `SESR_ZERO8) && !store_mode_in |=> status_byte_out[`SESR_STB_MAV];
  endproperty
  a_mav_set: assert property (p_mav_set) else $error("message flag missing");

  property p_mav_store;
    clk_en_in && store_mode_in && !meas_done_in |=> !status_byte_out[`SESR_STB_MAV];
  endproperty
  a_mav_store: assert property (p_mav_store) else $error("message flag early");

  property p_opc;
    clk_en_in && opc_done_in |=> standard_event_latch_q[`SESR_B_OPC];
  endproperty
  a_opc: assert property (p_opc) else $error("operation complete not latched");

  property p_pon;
    clk_en_in && (st_q == sesr_st_init) |=> standard_event_latch_q[`SESR_B_PON];
  endproperty
  a_pon: assert property (p_pon) else $error("power-on bit missing");

  property p_overload;
    clk_en_in && overload_in && !err_log_d |=> !err_log_out && standard_event_latch_q[`SESR_B_DEV];
  endproperty
  a_overload: assert property (p_overload) else $error("overload handling wrong");

  property p_clear;
    clk_en_in && (cls_in || esr_query_in) && (ev == `SESR_ZERO8) |=> standard_event_latch_q == `SESR_ZERO8;
  endproperty
  a_clear: assert property (p_clear) else $error("event register not cleared");

  property p_halt;
    clk_en_in && (cnt_d == `SESR_OBUF_DEPTH) |=> halt_readings_out;
  endproperty
  a_halt: assert property (p_halt) else $error("readings not halted");

  property p_zero_bits;
    ((status_byte_out & ~`SESR_STB_USED_MASK) == `SESR_ZERO8)
    && ((standard_event_latch_q & ~`SESR_USED_MASK) == `SESR_ZERO8);
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bit set");

endmodule

// ### shared/sesr_map.svh
`ifndef SESR_MAP_SVH
`define SESR_MAP_SVH
`define SESR_B_OPC 0
`define SESR_B_QRY 2
`define SESR_B_DEV 3
`define SESR_B_EXE 4
`define SESR_B_CMD 5
`define SESR_B_PON 7
`define SESR_USED_MASK 8'hBD
`define SESR_STB_QUES 3
`define SESR_STB_MAV 4
`define SESR_STB_ESS 5
`define SESR_STB_RQS 6
`define SESR_SRE_MASK 8'hBF
`define SESR_STB_USED_MASK 8'h78
`define SESR_ZERO8 8'h00
`define SESR_OBUF_DEPTH 8'h10
`define SESR_ONE8 8'h01
`endif

// ### shared/sesr_pkg.sv
package sesr_pkg;
  typedef enum logic [1:0] {
    sesr_st_init = 2'b01,
    sesr_st_run = 2'b10
  } sesr_state_t;
endpackage
